// file: core/ctp_pkg.sv
package ctp_pkg;

	// byte addresses of the word-aligned registers
	localparam logic [7:0] CTP_ADR_TSC      = 8'h20;
	localparam logic [7:0] CTP_ADR_COUNT    = 8'h24;
	localparam logic [7:0] CTP_ADR_MODULO   = 8'h28;
	localparam logic [7:0] CTP_ADR_CH0_CFG  = 8'h2C;
	localparam logic [7:0] CTP_ADR_CH0_VAL  = 8'h30;
	localparam logic [7:0] CTP_ADR_CH1_CFG  = 8'h34;
	localparam logic [7:0] CTP_ADR_CH1_VAL  = 8'h38;
	localparam logic [7:0] CTP_ADR_IRQ_STS  = 8'h3C;
	localparam logic [7:0] CTP_ADR_IRQ_MASK = 8'h40;

	// timer_status_control fields
	localparam int CTP_TSC_OVF    = 7;
	localparam int CTP_TSC_IE     = 6;
	localparam int CTP_TSC_HALT   = 5;
	localparam int CTP_TSC_CRST   = 4;
	localparam int CTP_TSC_PS_LSB = 0;
	localparam int CTP_TSC_PS_W   = 3;

	// channel config fields
	localparam int CTP_CFG_ACT_LSB = 0;
	localparam int CTP_CFG_MODE    = 2;
	localparam int CTP_CFG_OVF_TGL = 3;
	localparam int CTP_CFG_BUF     = 4;
	localparam int CTP_CFG_W       = 5;

	// interrupt status bits
	localparam int CTP_IRQ_OVF = 0;
	localparam int CTP_IRQ_CH0 = 1;
	localparam int CTP_IRQ_CH1 = 2;
	localparam int CTP_IRQ_W   = 3;

	localparam logic [15:0] CTP_MODULO_RST = 16'hFFFF;
	localparam logic        CTP_HALT_RST   = 1'b1;
	localparam logic [2:0]  CTP_PS_EXT     = 3'h7;
	localparam int          CTP_PRE_W      = 6;
	localparam int          CTP_CNT_W      = 16;

	// capture: edge select; compare: pin action
	typedef enum logic [1:0] {
		CTP_ACT_NONE = 2'h0,
		CTP_ACT_A    = 2'h1,
		CTP_ACT_B    = 2'h2,
		CTP_ACT_BOTH = 2'h3
	} ctp_act_type;

	typedef struct packed {
		logic        buffered;
		logic        ovf_toggle;
		logic        compare;
		ctp_act_type act;
	} ctp_chan_cfg_type;

	typedef struct packed {
		logic        tick;
		logic        wrap;
		logic [15:0] count;
	} ctp_time_type;

endpackage

// file: core/ctp_channel.sv
`timescale 1ns/1ps
module ctp_channel
	import ctp_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire ctp_chan_cfg_type cfg_i,
	input  wire ctp_time_type     time_i,
	input  wire logic [15:0]      cmp_i,
	input  wire logic             pin_i,
	output logic                  pin_o,
	output logic                  pin_oe_o,
	output logic                  event_o
);

	logic [2:0] sync_q;
	logic       filt_q;
	logic       pin_q;
	logic       agree;
	logic       rise;
	logic       fall;
	logic       edge_hit;
	logic       match;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], pin_i};
		end
	end

	// only stages two and three are looked at; stage one may be metastable
	assign agree = (sync_q[1] == sync_q[2]);
	assign rise  = agree & sync_q[2] & ~filt_q;
	assign fall  = agree & ~sync_q[2] & filt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_q <= 1'b0;
		end else if (agree) begin
			filt_q <= sync_q[2];
		end
	end

	always_comb begin
		case (cfg_i.act)
			CTP_ACT_A:    edge_hit = rise;
			CTP_ACT_B:    edge_hit = fall;
			CTP_ACT_BOTH: edge_hit = rise | fall;
			default:      edge_hit = 1'b0;
		endcase
	end

	assign match = time_i.tick & (time_i.count == cmp_i);

	// match action wins over the wrap toggle when both fall on one tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 1'b0;
		end else if (cfg_i.compare && match) begin
			case (cfg_i.act)
				CTP_ACT_A:    pin_q <= ~pin_q;
				CTP_ACT_B:    pin_q <= 1'b0;
				CTP_ACT_BOTH: pin_q <= 1'b1;
				default:      pin_q <= pin_q;
			endcase
		end else if (cfg_i.compare && cfg_i.ovf_toggle && time_i.wrap) begin
			pin_q <= ~pin_q;
		end
	end

	assign pin_o    = pin_q;
	assign pin_oe_o = cfg_i.compare;
	assign event_o  = cfg_i.compare ? match : edge_hit;

endmodule

// file: core/ctp_timer.sv
`timescale 1ns/1ps
module ctp_timer
	import ctp_pkg::*;
#(
	parameter bit HAS_EXT_CLK = 1'b0,
	parameter int NUM_CHAN    = 2
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	output logic             irq_o,
	input  wire logic        ext_clk_i,
	input  wire logic [1:0]  chan_pin_i,
	output logic [1:0]       chan_pin_o,
	output logic [1:0]       chan_pin_oe_o
);

	if (NUM_CHAN != 2) begin : g_chan_check
		$error("ctp_timer serves exactly two channels");
	end

	logic                   ack_q;
	logic [31:0]            dat_q;
	logic                   req;
	logic                   wr;
	logic                   rd;
	logic [15:0]            cnt_q;
	logic [15:0]            mod_q;
	logic [CTP_PRE_W-1:0]   pre_q;
	logic                   halt_q;
	logic [2:0]             ps_q;
	logic                   crst;
	logic [CTP_IRQ_W-1:0]   sts_q;
	logic [CTP_IRQ_W-1:0]   mask_q;
	logic [CTP_IRQ_W-1:0]   sts_set;
	logic [CTP_IRQ_W-1:0]   sts_clr;
	logic [6:0]             ps_onehot;
	logic [CTP_PRE_W-1:0]   pre_mask;
	logic                   int_tick;
	logic                   tick;
	logic                   wrap;
	ctp_time_type           tm;
	ctp_chan_cfg_type       cfg_q   [NUM_CHAN];
	logic [15:0]            val_q   [NUM_CHAN];
	logic [15:0]            shadow_q[NUM_CHAN];
	logic [NUM_CHAN-1:0]    ch_event;
	logic [2:0]             ext_sync_q;
	logic                   ext_filt_q;
	logic                   ext_agree;
	logic                   ext_rise;

	// bus slave: one wait state, ack for one cycle per request
	assign req = cyc_i & stb_i & ~ack_q;
	assign wr  = req & we_i;
	assign rd  = req & ~we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// external clock pin synchroniser, counts rising edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_sync_q <= 3'h0;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], ext_clk_i};
		end
	end

	assign ext_agree = (ext_sync_q[1] == ext_sync_q[2]);
	assign ext_rise  = ext_agree & ext_sync_q[2] & ~ext_filt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_filt_q <= 1'b0;
		end else if (ext_agree) begin
			ext_filt_q <= ext_sync_q[2];
		end
	end

	// prescaler: divide by 1,2,4,8,16,32,64
	assign ps_onehot = 7'h01 << ps_q;
	assign pre_mask  = CTP_PRE_W'(ps_onehot - 7'h01);
	assign int_tick  = ((pre_q & pre_mask) == pre_mask);

	always_comb begin
		if (halt_q) begin
			tick = 1'b0;
		end else if (ps_q == CTP_PS_EXT) begin
			tick = HAS_EXT_CLK & ext_rise;
		end else begin
			tick = int_tick;
		end
	end

	assign crst = wr && (adr_i == CTP_ADR_TSC) && sel_i[0]
		&& dat_i[CTP_TSC_CRST];

	always_ff @(posedge clk_i) begin
		if (rst_i || crst) begin
			pre_q <= '0;
		end else if (!halt_q) begin
			pre_q <= pre_q + CTP_PRE_W'(1);
		end
	end

	// a limit of all ones leaves the counter free-running
	assign wrap = tick && (cnt_q == mod_q);

	always_ff @(posedge clk_i) begin
		if (rst_i || crst) begin
			cnt_q <= 16'h0000;
		end else if (wrap) begin
			cnt_q <= 16'h0000;
		end else if (tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	assign tm.tick  = tick;
	assign tm.wrap  = wrap;
	assign tm.count = cnt_q;

	// control bits and modulo limit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_q <= CTP_HALT_RST;
			ps_q   <= 3'h0;
		end else if (wr && adr_i == CTP_ADR_TSC && sel_i[0]) begin
			halt_q <= dat_i[CTP_TSC_HALT];
			ps_q   <= dat_i[CTP_TSC_PS_LSB +: CTP_TSC_PS_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mod_q <= CTP_MODULO_RST;
		end else if (wr && adr_i == CTP_ADR_MODULO) begin
			if (sel_i[1]) begin
				mod_q[15:8] <= dat_i[15:8];
			end
			if (sel_i[0]) begin
				mod_q[7:0] <= dat_i[7:0];
			end
		end
	end

	// per-channel state: config, capture/compare value, pwm shadow
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		localparam logic [7:0] ADR_CFG = c ? CTP_ADR_CH1_CFG : CTP_ADR_CH0_CFG;
		localparam logic [7:0] ADR_VAL = c ? CTP_ADR_CH1_VAL : CTP_ADR_CH0_VAL;
		logic wr_val;

		assign wr_val = wr && (adr_i == ADR_VAL);

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cfg_q[c] <= '0;
			end else if (wr && adr_i == ADR_CFG && sel_i[0]) begin
				cfg_q[c] <= ctp_chan_cfg_type'(dat_i[CTP_CFG_W-1:0]);
			end
		end

		// software writes always land in the shadow; unbuffered writes also load val_q directly
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				shadow_q[c] <= 16'h0000;
			end else if (wr_val) begin
				if (sel_i[1]) begin
					shadow_q[c][15:8] <= dat_i[15:8];
				end
				if (sel_i[0]) begin
					shadow_q[c][7:0] <= dat_i[7:0];
				end
			end
		end

		// buffered duty loads only at wrap so a period is never cut short
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				val_q[c] <= 16'h0000;
			end else if (!cfg_q[c].compare && ch_event[c]) begin
				val_q[c] <= cnt_q;
			end else if (cfg_q[c].compare && cfg_q[c].buffered && wrap) begin
				val_q[c] <= shadow_q[c];
			end else if (wr_val && !cfg_q[c].buffered) begin
				if (sel_i[1]) begin
					val_q[c][15:8] <= dat_i[15:8];
				end
				if (sel_i[0]) begin
					val_q[c][7:0] <= dat_i[7:0];
				end
			end
		end

		ctp_channel u_chan (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.cfg_i    (cfg_q[c]),
			.time_i   (tm),
			.cmp_i    (val_q[c]),
			.pin_i    (chan_pin_i[c]),
			.pin_o    (chan_pin_o[c]),
			.pin_oe_o (chan_pin_oe_o[c]),
			.event_o  (ch_event[c])
		);
	end

	// sticky events, write one to clear; a new event beats the clear
	assign sts_set = {ch_event[1], ch_event[0], wrap};
	assign sts_clr = (wr && adr_i == CTP_ADR_IRQ_STS && sel_i[0])
		? dat_i[CTP_IRQ_W-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sts_q <= '0;
		end else begin
			sts_q <= (sts_q & ~sts_clr) | sts_set;
		end
	end

	// the overflow enable is one flop reachable from two addresses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= '0;
		end else if (wr && adr_i == CTP_ADR_IRQ_MASK && sel_i[0]) begin
			mask_q <= dat_i[CTP_IRQ_W-1:0];
		end else if (wr && adr_i == CTP_ADR_TSC && sel_i[0]) begin
			mask_q[CTP_IRQ_OVF] <= dat_i[CTP_TSC_IE];
		end
	end

	assign irq_o = |(sts_q & mask_q);

	// read data; reading the counter has no side effect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (rd) begin
			dat_q <= 32'h0000_0000;
			case (adr_i)
				CTP_ADR_TSC: begin
					dat_q[CTP_TSC_OVF]  <= sts_q[CTP_IRQ_OVF];
					dat_q[CTP_TSC_IE]   <= mask_q[CTP_IRQ_OVF];
					dat_q[CTP_TSC_HALT] <= halt_q;
					dat_q[CTP_TSC_PS_LSB +: CTP_TSC_PS_W] <= ps_q;
				end
				CTP_ADR_COUNT: begin
					dat_q[15:0] <= cnt_q;
				end
				CTP_ADR_MODULO: begin
					dat_q[15:0] <= mod_q;
				end
				CTP_ADR_CH0_CFG: begin
					dat_q[CTP_CFG_W-1:0] <= cfg_q[0];
				end
				CTP_ADR_CH0_VAL: begin
					dat_q[15:0] <= val_q[0];
				end
				CTP_ADR_CH1_CFG: begin
					dat_q[CTP_CFG_W-1:0] <= cfg_q[1];
				end
				CTP_ADR_CH1_VAL: begin
					dat_q[15:0] <= val_q[1];
				end
				CTP_ADR_IRQ_STS: begin
					dat_q[CTP_IRQ_W-1:0] <= sts_q;
				end
				CTP_ADR_IRQ_MASK: begin
					dat_q[CTP_IRQ_W-1:0] <= mask_q;
				end
				default: begin
					dat_q <= 32'h0000_0000;
				end
			endcase
		end
	end

endmodule

// file: verification/ctp_timer_assertions.sv
`timescale 1ns/1ps
module ctp_timer_chk
	import ctp_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        irq_o,
	input wire logic [1:0]  chan_pin_o,
	input wire logic [1:0]  chan_pin_oe_o
);
	logic rq;
	logic wr;
	assign rq = cyc_i & stb_i & ~ack_o;
	assign wr = rq & we_i & sel_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (rq |=> ack_o)
		else $error("no ack");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property (ack_o |-> $past(rq))
		else $error("stray ack");
	chk_miss_zero: assert property (rq && !we_i && adr_i == 8'h10
		|=> dat_o == 32'h0) else $error("unmapped read");
	chk_crst_zero: assert property (rq && !we_i
		&& adr_i == CTP_ADR_TSC |=> !dat_o[CTP_TSC_CRST])
		else $error("reset bit read");
	chk_mask_off: assert property (wr && adr_i == CTP_ADR_IRQ_MASK
		&& dat_i[2:0] == 3'h0 |=> !irq_o) else $error("irq masked");
	chk_oe_mode: assert property (wr && adr_i == CTP_ADR_CH0_CFG
		|=> chan_pin_oe_o[0] == $past(dat_i[CTP_CFG_MODE]))
		else $error("oe vs mode");
	chk_oe_cause: assert property ($changed(chan_pin_oe_o)
		|-> $past(rq && we_i)) else $error("oe moved");
	cover property (wr && adr_i == CTP_ADR_TSC);
	cover property ($rose(irq_o));
	cover property ($rose(chan_pin_o[0]));
endmodule

bind ctp_timer ctp_timer_chk i_chk (
	.clk_i        (clk_i),
	.rst_i        (rst_i),
	.cyc_i        (cyc_i),
	.stb_i        (stb_i),
	.we_i         (we_i),
	.adr_i        (adr_i),
	.sel_i        (sel_i),
	.dat_i        (dat_i),
	.dat_o        (dat_o),
	.ack_o        (ack_o),
	.irq_o        (irq_o),
	.chan_pin_o   (chan_pin_o),
	.chan_pin_oe_o(chan_pin_oe_o)
);

// file: verification/ctp_pin_model.sv
`timescale 1ns/1ps
module ctp_pin_model (
	input  wire logic [1:0] drv_i,
	input  wire logic [1:0] lvl_i,
	input  wire logic [1:0] oe_i,
	output logic [1:0]      pin_o
);
	// outside driver only wins where the timer leaves the pin alone
	assign pin_o = (oe_i & lvl_i) | (~oe_i & drv_i);
endmodule

// file: verification/ctp_timer_test.sv
`timescale 1ns/1ps
module ctp_timer_test import ctp_pkg::*;;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic [3:0]  sel_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        irq_o;
	logic [1:0]  drv;
	logic [1:0]  pin_i;
	logic [1:0]  pin_o;
	logic [1:0]  oe;
	logic [31:0] rd;
	int          failures;
	int          cmp_count;
	int          cc, ta, c1, t1, m, l, g, tw;

	ctp_timer i_dut (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.cyc_i        (cyc_i),
		.stb_i        (stb_i),
		.we_i         (we_i),
		.adr_i        (adr_i),
		.sel_i        (sel_i),
		.dat_i        (dat_i),
		.dat_o        (dat_o),
		.ack_o        (ack_o),
		.irq_o        (irq_o),
		.ext_clk_i    (1'b0),
		.chan_pin_i   (pin_i),
		.chan_pin_o   (pin_o),
		.chan_pin_oe_o(oe)
	);
	ctp_pin_model i_pins (.drv_i(drv), .lvl_i(pin_o), .oe_i(oe), .pin_o(pin_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cc <= cc + 1;

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		sel_i <= 4'h3;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 9);
		rd = dat_o;
		ta = cc;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 9) failures++;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// two counter reads; l is the cycle distance between their samples
	task automatic span(input int k);
		bus(1'b0, CTP_ADR_COUNT, 0);
		c1 = rd;
		t1 = ta;
		repeat (k) @(posedge clk_i);
		bus(1'b0, CTP_ADR_COUNT, 0);
		l = ta - t1;
	endtask

	// whole run needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		close_out;
	end

	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		sel_i = 4'h0;
		we_i = 1'b0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		drv = 2'h0;
		cc = 0;
		failures = 0;
		cmp_count = 0;
		void'($urandom(25831));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, CTP_ADR_TSC, 0);
		chk(rd, 32'h20);
		bus(1'b0, CTP_ADR_MODULO, 0);
		chk(rd, 32'hFFFF);
		bus(1'b0, 8'h10, 0);
		chk(rd, 32'h0);
		$display("reset values done");
		repeat (4) begin
			m = $urandom_range(40, 3);
			bus(1'b1, CTP_ADR_MODULO, m);
			bus(1'b1, CTP_ADR_TSC, 32'h10);
			span($urandom_range(90, 1));
			chk(rd, (c1 + l) % (m + 1));
		end
		$display("modulo wrap done");
		bus(1'b1, CTP_ADR_MODULO, 32'hFFFF);
		for (int p = 0; p < 7; p++) begin
			bus(1'b1, CTP_ADR_TSC, 32'h10 | p);
			tw = ta;
			span(200);
			// ticks land on every 2**p-th edge after the counter reset
			g = ((ta - tw - 1) >> p) - ((t1 - tw - 1) >> p);
			chk(rd - c1, g);
		end
		bus(1'b1, CTP_ADR_TSC, 32'h20);
		span(20);
		chk(rd, c1);
		$display("prescale and halt done");
		bus(1'b1, CTP_ADR_MODULO, 5);
		bus(1'b1, CTP_ADR_TSC, 32'h50);
		repeat (20) @(posedge clk_i);
		bus(1'b1, CTP_ADR_TSC, 32'h60);
		chk(irq_o, 1);
		bus(1'b0, CTP_ADR_TSC, 0);
		chk(rd[7], 1);
		bus(1'b1, CTP_ADR_IRQ_MASK, 0);
		chk(irq_o, 0);
		bus(1'b1, CTP_ADR_IRQ_MASK, 1);
		bus(1'b1, CTP_ADR_IRQ_STS, 1);
		chk(irq_o, 0);
		$display("overflow irq done");
		bus(1'b1, CTP_ADR_MODULO, 15);
		bus(1'b1, CTP_ADR_CH0_VAL, 7);
		for (int a = 2; a < 4; a++) begin
			bus(1'b1, CTP_ADR_CH0_CFG, 4 | a);
			bus(1'b1, CTP_ADR_TSC, 32'h10);
			repeat (40) @(posedge clk_i);
			chk(pin_o[0], a == 3);
		end
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, CTP_ADR_CH0_CFG, i ? 32'hC : 32'h5);
			repeat (3) @(posedge clk_i);
			g = pin_o[0];
			repeat (16) @(posedge clk_i);
			chk(pin_o[0], !g);
		end
		bus(1'b1, CTP_ADR_TSC, 32'h20);
		bus(1'b1, CTP_ADR_CH0_CFG, 32'h17);
		bus(1'b1, CTP_ADR_CH0_VAL, 9);
		bus(1'b0, CTP_ADR_CH0_VAL, 0);
		chk(rd, 32'h7);
		bus(1'b1, CTP_ADR_TSC, 0);
		repeat ($urandom_range(30, 20)) @(posedge clk_i);
		bus(1'b1, CTP_ADR_TSC, 32'h20);
		bus(1'b0, CTP_ADR_CH0_VAL, 0);
		chk(rd, 32'h9);
		$display("compare and pwm done");
		bus(1'b0, CTP_ADR_COUNT, 0);
		c1 = rd;
		for (int a = 1; a < 4; a++) begin
			bus(1'b1, CTP_ADR_CH1_CFG, a);
			for (int e = 0; e < 2; e++) begin
				drv[1] <= e[0];
				repeat (8) @(posedge clk_i);
				bus(1'b1, CTP_ADR_IRQ_STS, 4);
				drv[1] <= !e[0];
				repeat (8) @(posedge clk_i);
				bus(1'b0, CTP_ADR_IRQ_STS, 0);
				chk(rd[2], a >> e & 1);
			end
		end
		bus(1'b0, CTP_ADR_CH1_VAL, 0);
		chk(rd, c1);
		chk(oe, 2'h1);
		$display("capture done");
		close_out;
	end
endmodule
